/* File: design/pocc_if.sv */
// pocc_if: applied channel setting passed from the register bank to the output gate.
// assumes both ends run on the same clock.
`default_nettype none
interface pocc_if;
    logic [31:0] chan_width;
    logic [31:0] bit_mask;
    modport bank (output chan_width, output bit_mask);
    modport gate (input chan_width, input bit_mask);
endinterface : pocc_if
`default_nettype wire

/* File: design/pocc_out_gate.sv */
// pocc_out_gate: combines channel width and per-bit mask into output enables.
// assumes inputs are registered run settings on the same clock.
`default_nettype none
module pocc_out_gate (
    pocc_if.gate              cfg,
    output logic [31:0]       drive_en_o
);
    logic [31:0] chan_allow;

    // ****************************************
    // per-bit allow from channel width
    // ****************************************
    for (genvar b = 0; b < pocc_pkg::NUM_OUT; b++) begin : g_bit
        localparam bit MOD1 = (b >= pocc_pkg::MOD_WIDTH);
        localparam int LO   = MOD1 ? pocc_pkg::M1_LO : pocc_pkg::M0_LO;
        localparam int HI   = MOD1 ? pocc_pkg::M1_HI : pocc_pkg::M0_HI;
        always_comb begin
            if (!cfg.chan_width[LO])
                chan_allow[b] = 1'b0;                            // [R12]
            else if (!cfg.chan_width[HI])
                chan_allow[b] = !pocc_pkg::ODD_BITS[b];          // [R13]
            else
                chan_allow[b] = 1'b1;
        end
    end

    // mask can only take bits away, never add [R12] [R11]
    assign drive_en_o = chan_allow & cfg.bit_mask;
endmodule : pocc_out_gate
`default_nettype wire

/* File: design/pocc_pkg.sv */
// pocc_pkg: constants for the pattern output channel configuration block.
// assumes a register port addressed by the register's documented value.
`default_nettype none
package pocc_pkg;
    // ****************************************
    // register addresses (documented values)
    // ****************************************
    localparam logic [31:0] ADDR_BOARD_COMMAND = 32'h0000_0000;
    localparam logic [31:0] ADDR_CHANNEL_WIDTH = 32'h0000_2af8;
    localparam logic [31:0] ADDR_BIT_ENABLE    = 32'h0000_2b16;
    // ****************************************
    // command codes
    // ****************************************
    localparam logic [31:0] CMD_FULL_RESET     = 32'h0000_0000;
    localparam logic [31:0] CMD_LOW_POWER      = 32'h0000_001e;
    // ****************************************
    // channel width masks
    // ****************************************
    localparam logic [31:0] CW_MODULE0_NARROW  = 32'h0000_0001;
    localparam logic [31:0] CW_MODULE0_WIDE    = 32'h0000_0003;
    localparam logic [31:0] CW_MODULE1_NARROW  = 32'h0000_0010;
    localparam logic [31:0] CW_MODULE1_WIDE    = 32'h0000_0030;
    localparam logic [31:0] CW_BOTH_NARROW     = 32'h0000_0011;
    localparam logic [31:0] CW_BOTH_WIDE       = 32'h0000_0033;
    localparam logic [31:0] CW_RESET           = 32'h0000_0001;
    localparam logic [31:0] BIT_ENABLE_RESET   = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD          = 32'h0000_0000;
    // ****************************************
    // field positions and widths
    // ****************************************
    localparam int          NUM_OUT            = 32;
    localparam int          MOD_WIDTH          = 16;
    localparam int          M0_LO              = 0;
    localparam int          M0_HI              = 1;
    localparam int          M1_LO              = 4;
    localparam int          M1_HI              = 5;
    localparam logic [31:0] ODD_BITS           = 32'haaaa_aaaa;

    typedef enum logic [1:0] {
        POCC_RUN_NORMAL = 2'b01,
        POCC_RUN_LOWPWR = 2'b10
    } pocc_power_e;
endpackage : pocc_pkg
`default_nettype wire

/* File: design/pocc_top.sv */
// pocc_top: command, channel width and bit enable registers of the pattern board.
// assumes a single-cycle register port on clk_i; memory and run logic sit outside.
//
// Functional notes
// (R01) power-down command puts the board in low-power mode.
// (R02) reset command or run start returns the board to normal mode.
// (R03) power-down or reset invalidates sample memory contents.
// (R04) reset command restores every setting to its default.
// (R05) width masks: 1/3 for module 0, 16/48 for module 1.
// (R06) software ORs module values; only both-narrow or both-wide valid. The code also keeps the module-0-only masks 1 and 3 as valid.
// (R07) invalid width masks are remapped; reads return applied mask.
// (R08) width setting takes effect at next run start.
// (R09) disabled output bits are tristated.
// (R10) per-bit enable mask is 32-bit read/write, 1 enables.
// (R11) upper half controls module 1, lower half module 0.
// (R12) output enabled only if mask and channel setting both allow.
// (R13) narrow modes keep odd output bits disabled.
// (R14) per-bit mask resets to zero.
// (R15) software programs one width option per module.
// (R16) unknown command codes are ignored.
`default_nettype none
module pocc_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // register port
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // run control from sequencer
    input  wire logic        run_start_i,
    // status
    output logic             low_power_o,
    output logic             mem_valid_o,
    output logic      [31:0] run_chan_width_o,
    // pattern pins
    input  wire logic [31:0] pattern_i,
    output logic      [31:0] pin_o,
    output logic      [31:0] pin_oe_n_o
);
    pocc_if cfg_bus ();

    pocc_pkg::pocc_power_e power_q, power_d;
    logic        low_power_q, low_power_d;
    logic [31:0] cw_q, cw_d;
    logic [31:0] run_cw_q, run_cw_d;
    logic [31:0] mask_q, mask_d;
    logic [31:0] run_mask_q, run_mask_d;
    logic        mem_valid_q, mem_valid_d;
    logic [31:0] rdata_q, rdata_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] pin_q, pin_d;
    logic [31:0] oe_n_q, oe_n_d;
    logic [31:0] drive_en;
    logic        wr_cmd, cmd_reset, cmd_lowpwr;

    // ****************************************
    // width remap
    // ****************************************
    // module 1 alone is not a legal mask; narrow maps to module 0 narrow, wide maps to both wide
    function automatic logic [31:0] remap_width(input logic [31:0] v);
        logic m0n, m0w, m1n, m1w;
        m0n = v[pocc_pkg::M0_LO];
        m0w = v[pocc_pkg::M0_HI];
        m1n = v[pocc_pkg::M1_LO];
        m1w = v[pocc_pkg::M1_HI];
        if (m0w || m1w) begin
            if (m1n || m1w)
                remap_width = pocc_pkg::CW_BOTH_WIDE;                // [R07]
            else
                remap_width = pocc_pkg::CW_MODULE0_WIDE;
        end else if (m0n && m1n)
            remap_width = pocc_pkg::CW_BOTH_NARROW;
        else
            remap_width = pocc_pkg::CW_MODULE0_NARROW;
    endfunction

    assign wr_cmd     = reg_wr_i && (reg_addr_i == pocc_pkg::ADDR_BOARD_COMMAND);
    assign cmd_reset  = wr_cmd && (reg_wdata_i == pocc_pkg::CMD_FULL_RESET);
    assign cmd_lowpwr = wr_cmd && (reg_wdata_i == pocc_pkg::CMD_LOW_POWER);

    // ****************************************
    // register bank next state
    // ****************************************
    always_comb begin
        power_d     = power_q;
        cw_d        = cw_q;
        run_cw_d    = run_cw_q;
        mask_d      = mask_q;
        run_mask_d  = run_mask_q;
        mem_valid_d = mem_valid_q;
        if (reg_wr_i && reg_addr_i == pocc_pkg::ADDR_CHANNEL_WIDTH)
            cw_d = remap_width(reg_wdata_i);                         // [R05] [R07]
        if (reg_wr_i && reg_addr_i == pocc_pkg::ADDR_BIT_ENABLE)
            mask_d = reg_wdata_i;                                    // [R10]
        if (run_start_i) begin
            run_cw_d    = cw_d;                                      // [R08]
            run_mask_d  = mask_d;
            power_d     = pocc_pkg::POCC_RUN_NORMAL;                 // [R02]
            mem_valid_d = 1'b1;
        end
        // other codes fall through untouched [R16]
        if (cmd_lowpwr) begin
            power_d     = pocc_pkg::POCC_RUN_LOWPWR;                 // [R01]
            mem_valid_d = 1'b0;                                      // [R03]
        end
        if (cmd_reset) begin
            power_d     = pocc_pkg::POCC_RUN_NORMAL;                 // [R02]
            cw_d        = pocc_pkg::CW_RESET;                        // [R04]
            run_cw_d    = pocc_pkg::CW_RESET;
            mask_d      = pocc_pkg::BIT_ENABLE_RESET;                // [R14]
            run_mask_d  = pocc_pkg::BIT_ENABLE_RESET;
            mem_valid_d = 1'b0;                                      // [R03]
        end
        // status flag has its own flop so the port needs no decode
        low_power_d = (power_d == pocc_pkg::POCC_RUN_LOWPWR);        // [R01]
    end

    // ****************************************
    // readback
    // ****************************************
    always_comb begin
        rvalid_d = reg_rd_i;
        rdata_d  = pocc_pkg::ZERO_WORD;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                pocc_pkg::ADDR_BOARD_COMMAND: rdata_d = pocc_pkg::ZERO_WORD;
                pocc_pkg::ADDR_CHANNEL_WIDTH: rdata_d = cw_q;        // [R07]
                pocc_pkg::ADDR_BIT_ENABLE:    rdata_d = mask_q;      // [R10]
                default:                      rdata_d = pocc_pkg::ZERO_WORD;
            endcase
        end
    end

    // ****************************************
    // output pins
    // ****************************************
    assign cfg_bus.chan_width = run_cw_q;
    assign cfg_bus.bit_mask   = run_mask_q;

    pocc_out_gate u_gate (
        .cfg        (cfg_bus),
        .drive_en_o (drive_en)
    );

    always_comb begin
        // low power drops every driver as well
        if (low_power_q)
            oe_n_d = ~pocc_pkg::ZERO_WORD;
        else
            oe_n_d = ~drive_en;                                      // [R09] [R12]
        // data follows the enable, so a released pin never carries pattern bits
        pin_d = pattern_i & ~oe_n_d;                                 // [R09]
    end

    // ****************************************
    // register bank flops
    // ****************************************
    // run copies feed the pins; front copies are what software reads back
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            power_q     <= pocc_pkg::POCC_RUN_NORMAL;
            low_power_q <= 1'b0;
            cw_q        <= pocc_pkg::CW_RESET;
            run_cw_q    <= pocc_pkg::CW_RESET;
            mask_q      <= pocc_pkg::BIT_ENABLE_RESET;               // [R14]
            run_mask_q  <= pocc_pkg::BIT_ENABLE_RESET;
            mem_valid_q <= 1'b0;
        end else begin
            power_q     <= power_d;
            low_power_q <= low_power_d;
            cw_q        <= cw_d;
            run_cw_q    <= run_cw_d;
            mask_q      <= mask_d;
            run_mask_q  <= run_mask_d;
            mem_valid_q <= mem_valid_d;
        end
    end

    // ****************************************
    // readback flops
    // ****************************************
    // one-cycle answer; a write in the read's cycle is not yet visible
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_q  <= pocc_pkg::ZERO_WORD;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ****************************************
    // pin flops
    // ****************************************
    // enables start released so nothing drives before software asks for it
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pin_q  <= pocc_pkg::ZERO_WORD;
            oe_n_q <= ~pocc_pkg::ZERO_WORD;                          // [R14]
        end else begin
            pin_q  <= pin_d;
            oe_n_q <= oe_n_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata_o      = rdata_q;
    assign reg_rvalid_o     = rvalid_q;
    assign low_power_o      = low_power_q;
    assign mem_valid_o      = mem_valid_q;
    assign run_chan_width_o = run_cw_q;
    assign pin_o            = pin_q;
    assign pin_oe_n_o       = oe_n_q;
endmodule : pocc_top
`default_nettype wire

/* File: tb/pocc_top_chk.sv */
// pocc_top_chk: port assertions for pocc_top.
// assumes one clock domain; bound from the foot of this file.
`default_nettype none
module pocc_top_chk (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    // register port
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_rvalid_o,
    // run and status
    input wire logic        run_start_i,
    input wire logic        low_power_o,
    input wire logic        mem_valid_o,
    input wire logic [31:0] run_chan_width_o,
    // pins
    input wire logic [31:0] pin_o,
    input wire logic [31:0] pin_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic cmd_wr, pd_wr, rst_wr, cw_wr;
    assign cmd_wr = reg_wr_i && reg_addr_i == pocc_pkg::ADDR_BOARD_COMMAND;
    assign pd_wr  = cmd_wr && reg_wdata_i == pocc_pkg::CMD_LOW_POWER;
    assign rst_wr = cmd_wr && reg_wdata_i == pocc_pkg::CMD_FULL_RESET;
    assign cw_wr  = reg_wr_i && reg_addr_i == pocc_pkg::ADDR_CHANNEL_WIDTH;
    // ****
    // pins follow run settings two edges after the run start
    // ****
    sequence s_run_applied;
        run_start_i ##1 1'b1;
    endsequence
    AST_RVALID: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    AST_PD_ENTER: assert property (pd_wr |=> low_power_o && !mem_valid_o)
        else $error("low power entry wrong");
    AST_PD_EXIT: assert property (low_power_o && (run_start_i || rst_wr) && !pd_wr |=> !low_power_o)
        else $error("low power not left");
    AST_RST_CMD: assert property (rst_wr |=> !low_power_o && !mem_valid_o)
        else $error("reset command state wrong");
    AST_BAD_CMD: assert property (cmd_wr && !pd_wr && !rst_wr && !run_start_i |=>
        $stable(low_power_o) && $stable(mem_valid_o)) else $error("unknown command acted on");
    AST_TRISTATE: assert property ((pin_o & pin_oe_n_o) == 32'h0000_0000)
        else $error("data on tristated pin");
    AST_NARROW_ODD: assert property (s_run_applied ##0 !run_chan_width_o[pocc_pkg::M0_HI] |=>
        (~pin_oe_n_o & pocc_pkg::ODD_BITS & 32'h0000_ffff) == 32'h0000_0000) else $error("odd bit enabled");
    AST_MOD1_OFF: assert property (s_run_applied ##0 !run_chan_width_o[pocc_pkg::M1_LO] |=>
        (~pin_oe_n_o & 32'hffff_0000) == 32'h0000_0000) else $error("module 1 pin enabled");
    AST_WIDTH_NEXT: assert property (cw_wr && !run_start_i |=> $stable(run_chan_width_o))
        else $error("width applied without run");
    AST_RESET_PINS: assert property ($rose(reset_n_i) |-> &pin_oe_n_o && !mem_valid_o)
        else $error("pins enabled after reset");
endmodule // pocc_top_chk
bind pocc_top pocc_top_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rvalid_o(reg_rvalid_o),
    .run_start_i(run_start_i), .low_power_o(low_power_o), .mem_valid_o(mem_valid_o),
    .run_chan_width_o(run_chan_width_o), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));
`default_nettype wire

/* File: tb/tb_pocc_top.sv */
// tb_pocc_top: register-level tests of pocc_top.
// assumes the package, interface and design compiled before it.
`default_nettype none
module tb_pocc_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, run_start_i = 0;
    logic        reg_rvalid_o, low_power_o, mem_valid_o;
    logic [31:0] reg_addr_i = '0, reg_wdata_i = '0, pattern_i = 32'h1234_5678;
    logic [31:0] reg_rdata_o, run_chan_width_o, pin_o, pin_oe_n_o;
    int          failures = 0, compares = 0;
    logic [31:0] wv [10] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0011, 32'h0000_0033, 32'h0000_0010,
                             32'h0000_0030, 32'h0000_0013, 32'h0000_0031, 32'h0000_0000, 32'h0000_0002};
    logic [31:0] ev [10] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0011, 32'h0000_0033, 32'h0000_0001,
                             32'h0000_0033, 32'h0000_0033, 32'h0000_0033, 32'h0000_0001, 32'h0000_0003};
    always #2 clk_i = ~clk_i;
    pocc_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .run_start_i(run_start_i), .low_power_o(low_power_o),
        .mem_valid_o(mem_valid_o), .run_chan_width_o(run_chan_width_o), .pattern_i(pattern_i),
        .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));
    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(negedge clk_i);
        reg_wr_i = 1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_i);
        reg_wr_i = 0;
    endtask
    // fixed one-cycle answer, so no polling is needed
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(negedge clk_i);
        reg_rd_i = 1;
        reg_addr_i = a;
        @(negedge clk_i);
        reg_rd_i = 0;
        chk(32'(reg_rvalid_o), 32'h0000_0001);
        chk(reg_rdata_o, exp);
    endtask
    task automatic start();
        @(negedge clk_i);
        run_start_i = 1;
        @(negedge clk_i);
        run_start_i = 0;
    endtask
    task automatic run(input logic [31:0] w, input logic [31:0] m, input logic [31:0] en);
        wr(pocc_pkg::ADDR_CHANNEL_WIDTH, w);
        wr(pocc_pkg::ADDR_BIT_ENABLE, m);
        start();
        chk(run_chan_width_o, w);
        @(negedge clk_i);
        chk(pin_oe_n_o, ~en);
        chk(pin_o, pattern_i & en);
    endtask
    initial begin
        #100us;
        failures++;
        finish_test();
    end
    initial begin
        repeat (3) @(negedge clk_i);
        reset_n_i = 1;
        rd(pocc_pkg::ADDR_CHANNEL_WIDTH, pocc_pkg::CW_RESET);
        rd(pocc_pkg::ADDR_BIT_ENABLE, 32'h0000_0000);
        chk(pin_oe_n_o, 32'hffff_ffff);
        rd(32'h0000_0004, 32'h0000_0000);
        for (int i = 0; i < 10; i++) begin
            wr(pocc_pkg::ADDR_CHANNEL_WIDTH, wv[i]);
            rd(pocc_pkg::ADDR_CHANNEL_WIDTH, ev[i]);
        end
        wr(pocc_pkg::ADDR_BIT_ENABLE, 32'haaaa_5555);
        rd(pocc_pkg::ADDR_BIT_ENABLE, 32'haaaa_5555);
        run(32'h0000_0033, 32'haaaa_5555, 32'haaaa_5555);
        run(32'h0000_0011, 32'hffff_ffff, 32'h5555_5555);
        run(32'h0000_0001, 32'hffff_ffff, 32'h0000_5555);
        run(32'h0000_0003, 32'h0000_00ff, 32'h0000_00ff);
        wr(pocc_pkg::ADDR_CHANNEL_WIDTH, 32'h0000_0033);
        chk(run_chan_width_o, 32'h0000_0003);
        wr(pocc_pkg::ADDR_BOARD_COMMAND, 32'h0000_0005);
        chk(32'({low_power_o, mem_valid_o}), 32'h0000_0001);
        wr(pocc_pkg::ADDR_BOARD_COMMAND, pocc_pkg::CMD_LOW_POWER);
        chk(32'({low_power_o, mem_valid_o}), 32'h0000_0002);
        @(negedge clk_i);
        chk(pin_oe_n_o, 32'hffff_ffff);
        chk(pin_o, 32'h0000_0000);
        start();
        chk(32'({low_power_o, mem_valid_o}), 32'h0000_0001);
        wr(pocc_pkg::ADDR_BOARD_COMMAND, pocc_pkg::CMD_LOW_POWER);
        wr(pocc_pkg::ADDR_BOARD_COMMAND, pocc_pkg::CMD_FULL_RESET);
        chk(32'({low_power_o, mem_valid_o}), 32'h0000_0000);
        rd(pocc_pkg::ADDR_CHANNEL_WIDTH, pocc_pkg::CW_RESET);
        rd(pocc_pkg::ADDR_BIT_ENABLE, 32'h0000_0000);
        rd(pocc_pkg::ADDR_BOARD_COMMAND, 32'h0000_0000);
        finish_test();
    end
endmodule // tb_pocc_top
`default_nettype wire
